//--- logic/rtc_control_status_logic.v
// control and status registers, conversion sequencing and pin drive of the rtc
`default_nettype none
`include "rtc_ctrl_map.vh"
module rtc_control_status_logic #(
  parameter BUSY_HOLDOFF_CYCLES = `BUSY_HOLDOFF_CYCLES,
  parameter HOLD_W              = 20
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       arst_n,
  // register access port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  output wire [7:0] regRdData,
  // analog and pin inputs
  input  wire       oscClkPin,
  input  wire       powerFailPin,
  // alarm comparators and temperature sensor
  input  wire       alarmOneMatch,
  input  wire       alarmTwoMatch,
  input  wire       sensorDone,
  output wire       sensorConvert,
  output wire       capUpdate,
  // oscillator control
  output wire       oscEnable,
  // shared interrupt / square-wave pin, open drain
  output wire       irqWavePinOut,
  output wire       irqWavePinOe,
  // fixed-frequency pin
  output wire       fixedWavePinOut,
  output wire       fixedWavePinOe
);
  // ==========================================================
  // state encoding
  localparam [1:0] ST_IDLE       = 2'h0;
  localparam [1:0] ST_MEASURE    = 2'h1;
  localparam [1:0] ST_COMPENSATE = 2'h2;
  localparam integer      HOLD_LAST_I = BUSY_HOLDOFF_CYCLES - 1;
  // counter width truncates the holdoff to its low HOLD_W bits; the cut is deliberate
  localparam [HOLD_W-1:0] HOLD_LAST   = HOLD_LAST_I[HOLD_W-1:0];

  // ==========================================================
  // declarations
  wire [1:0]              syncLevel;
  wire                    oscLevel;
  wire                    onBattery;
  wire [`DIV_WIDTH-1:0]   divCount;
  wire                    secTick;
  reg                     oscPrev_ff;
  reg                     oscTick;
  reg                     halted;
  reg  [7:0]              control_ff;
  reg  [7:0]              applied_ff;
  reg                     convActive_ff;
  reg                     userRun_ff;
  reg                     oscStopped_ff;
  reg                     fixedEn_ff;
  reg                     busy_ff;
  reg                     alarmOne_ff;
  reg                     alarmTwo_ff;
  reg  [1:0]              state_ff;
  reg  [1:0]              nxt_state;
  reg  [HOLD_W-1:0]       hold_ff;
  reg  [5:0]              secCount_ff;
  reg                     autoDue_ff;
  reg  [7:0]              rdData_ff;
  reg                     sensorConvert_ff;
  reg                     capUpdate_ff;
  reg                     oscEnable_ff;
  reg                     irqOut_ff;
  reg                     irqOe_ff;
  reg                     fixedOut_ff;
  reg                     fixedOe_ff;
  reg                     ctlWr;
  reg                     stWr;
  reg                     startUser;
  reg                     startAuto;
  reg                     finish;
  reg                     waveSel;
  reg                     irqRequest;

  // ==========================================================
  // pin synchronisers and divider
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk    (sys_clk),
    .arst_n (arst_n),
    .pinIn  ({powerFailPin, oscClkPin}),
    .level  (syncLevel)
  );
  assign oscLevel  = syncLevel[0];
  assign onBattery = syncLevel[1];

  wave_divider #(
    .WIDTH (`DIV_WIDTH)
  ) u_div (
    .clk     (sys_clk),
    .arst_n  (arst_n),
    .oscTick (oscTick),
    .run     (~halted),
    .count   (divCount),
    .secTick (secTick)
  );

  // ==========================================================
  // decode and sequencing terms
  always @* begin
    ctlWr      = regWrEn && (regAddr == `REG_CONTROL_OFS);
    stWr       = regWrEn && (regAddr == `REG_STATUS_OFS);
    oscTick    = oscLevel && !oscPrev_ff;
    // main supply overrides the stop bit
    // a cleared stop bit acts at once: a halted oscillator brings no tick to copy it
    halted     = onBattery && applied_ff[`CTL_OSC_STOP] && control_ff[`CTL_OSC_STOP];
    // pending requests launch only on an oscillator tick
    startAuto  = (state_ff == ST_IDLE) && autoDue_ff && oscTick;
    startUser  = (state_ff == ST_IDLE) && !autoDue_ff && oscTick &&
                 convActive_ff && !userRun_ff;
    finish     = (state_ff == ST_COMPENSATE);
    case (applied_ff[`CTL_RATE_HI:`CTL_RATE_LO])
      `RATE_1HZ:   waveSel = divCount[`TAP_1HZ];
      `RATE_1K024: waveSel = divCount[`TAP_1K024];
      `RATE_4K096: waveSel = divCount[`TAP_4K096];
      default:     waveSel = divCount[`TAP_8K192];
    endcase
    irqRequest = (alarmOne_ff && control_ff[`CTL_ALARM1_EN]) ||
                 (alarmTwo_ff && control_ff[`CTL_ALARM2_EN]);
  end

  // ==========================================================
  // conversion state machine
  always @* begin
    case (state_ff)
      ST_IDLE: begin
        nxt_state = (startAuto || startUser) ? ST_MEASURE : ST_IDLE;
      end
      ST_MEASURE: begin
        nxt_state = sensorDone ? ST_COMPENSATE : ST_MEASURE;
      end
      ST_COMPENSATE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff         <= ST_IDLE;
      userRun_ff       <= 1'b0;
      hold_ff          <= {HOLD_W{1'b0}};
      sensorConvert_ff <= 1'b0;
      capUpdate_ff     <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      sensorConvert_ff <= (nxt_state == ST_MEASURE);
      // load the capacitance array once the reading is
      capUpdate_ff     <= (nxt_state == ST_COMPENSATE);
      if (startUser) begin
        userRun_ff <= 1'b1;
        hold_ff    <= {HOLD_W{1'b0}};
      end else if (finish) begin
        userRun_ff <= 1'b0;
      end else if (userRun_ff && hold_ff != HOLD_LAST) begin
        hold_ff <= hold_ff + {{(HOLD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // automatic schedule, counted in oscillator seconds only
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      secCount_ff <= 6'h00;
      autoDue_ff  <= 1'b0;
    end else begin
      // user runs neither reset nor delay this count
      if (secTick) begin
        secCount_ff <= secCount_ff + 6'h01;
      end
      if (secTick && secCount_ff == `AUTO_CONVERT_REQUEST_PERIOD_S - 1) begin
        autoDue_ff <= 1'b1;
      end else if (startAuto) begin
        autoDue_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // busy flag
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end else if (startAuto) begin
      busy_ff <= 1'b1;
    end else if (userRun_ff && hold_ff == HOLD_LAST && state_ff != ST_IDLE) begin
      // user run shows on busy only after the holdoff
      busy_ff <= 1'b1;
    end
  end

  // ==========================================================
  // control register and its oscillator-side copy
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_ff    <= `CONTROL_RESET;
      applied_ff    <= `CONTROL_RESET;
      convActive_ff <= 1'b0;
    end else begin
      if (ctlWr) begin
        control_ff <= regWrData;
      end
      if (oscTick) begin
        applied_ff <= control_ff;
      end
      if (finish && userRun_ff) begin
        convActive_ff <= 1'b0;
      end else if (ctlWr && regWrData[`CTL_CONVERT] && state_ff == ST_IDLE && !busy_ff) begin
        // a request during any run is dropped
        convActive_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // status flags; hardware set beats a software clear
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscStopped_ff <= `STATUS_STOP_RESET;
      fixedEn_ff    <= `STATUS_FIXED_RESET;
      alarmOne_ff   <= 1'b0;
      alarmTwo_ff   <= 1'b0;
    end else begin
      oscStopped_ff <= halted || (oscStopped_ff && !(stWr && !regWrData[`ST_OSC_STOP]));
      alarmOne_ff   <= alarmOneMatch ||
                       (alarmOne_ff && !(stWr && !regWrData[`ST_ALARM1]));
      alarmTwo_ff   <= alarmTwoMatch ||
                       (alarmTwo_ff && !(stWr && !regWrData[`ST_ALARM2]));
      if (stWr) begin
        fixedEn_ff <= regWrData[`ST_FIXED_EN];
      end
    end
  end

  // ==========================================================
  // read data, one cycle behind the address
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= 8'h00;
    end else if (regAddr == `REG_CONTROL_OFS) begin
      rdData_ff <= {control_ff[7:6], convActive_ff, control_ff[4:0]};
    end else if (regAddr == `REG_STATUS_OFS) begin
      rdData_ff <= {oscStopped_ff, 3'h0, fixedEn_ff, busy_ff, alarmTwo_ff, alarmOne_ff};
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  // ==========================================================
  // pin drive
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscPrev_ff   <= 1'b0;
      oscEnable_ff <= 1'b1;
      irqOut_ff    <= 1'b0;
      irqOe_ff     <= 1'b0;
      fixedOut_ff  <= 1'b0;
      fixedOe_ff   <= 1'b0;
    end else begin
      oscPrev_ff   <= oscLevel;
      oscEnable_ff <= !halted;
      // open drain: only ever pulls low
      irqOut_ff    <= 1'b0;
      if (onBattery && !applied_ff[`CTL_BAT_WAVE]) begin
        irqOe_ff <= 1'b0;
      end else if (applied_ff[`CTL_PIN_SEL]) begin
        irqOe_ff <= irqRequest;
      end else begin
        irqOe_ff <= !waveSel;
      end
      // follows the raw oscillator, so it also stops with it
      fixedOut_ff  <= oscLevel;
      fixedOe_ff   <= fixedEn_ff;
    end
  end

  // ==========================================================
  // outputs
  assign regRdData       = rdData_ff;
  assign sensorConvert   = sensorConvert_ff;
  assign capUpdate       = capUpdate_ff;
  assign oscEnable       = oscEnable_ff;
  assign irqWavePinOut   = irqOut_ff;
  assign irqWavePinOe    = irqOe_ff;
  assign fixedWavePinOut = fixedOut_ff;
  assign fixedWavePinOe  = fixedOe_ff;
endmodule // rtc_control_status_logic
`default_nettype wire

//--- logic/rtc_ctrl_map.vh
// register map, field positions, reset values and timing counts of the rtc control block
`ifndef RTC_CTRL_MAP_VH
`define RTC_CTRL_MAP_VH
// ==========================================================
// register offsets
`define REG_CONTROL_OFS      8'h0E
`define REG_STATUS_OFS       8'h0F
// ==========================================================
// control_settings fields
`define CTL_OSC_STOP         7
`define CTL_BAT_WAVE         6
`define CTL_CONVERT          5
`define CTL_RATE_HI          4
`define CTL_RATE_LO          3
`define CTL_PIN_SEL          2
`define CTL_ALARM2_EN        1
`define CTL_ALARM1_EN        0
`define CONTROL_RESET        8'h1C
// ==========================================================
// status_flags fields
`define ST_OSC_STOP          7
`define ST_FIXED_EN          3
`define ST_BUSY              2
`define ST_ALARM2            1
`define ST_ALARM1            0
`define STATUS_STOP_RESET    1'h1
`define STATUS_FIXED_RESET   1'h1
// ==========================================================
// square-wave rate codes and divider taps
`define RATE_1HZ             2'h0
`define RATE_1K024           2'h1
`define RATE_4K096           2'h2
`define RATE_8K192           2'h3
`define DIV_WIDTH            15
`define TAP_1HZ              14
`define TAP_1K024            4
`define TAP_4K096            2
`define TAP_8K192            1
// ==========================================================
// timing
`define SYS_CLK_KHZ          200000
`define BUSY_HOLDOFF_US      2000
`define BUSY_HOLDOFF_CYCLES  ((`BUSY_HOLDOFF_US * `SYS_CLK_KHZ) / 1000)
`define AUTO_CONVERT_REQUEST_PERIOD_S   64
`endif

//--- logic/pin_sync.v
// three-flop input synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // pins in, filtered levels out
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1_ff;
      reg stage2_ff;
      reg stage3_ff;
      reg level_ff;
      // only the second stage reads the first
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
          stage3_ff <= 1'b0;
          level_ff  <= 1'b0;
        end else begin
          stage1_ff <= pinIn[i];
          stage2_ff <= stage1_ff;
          stage3_ff <= stage2_ff;
          if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
          end
        end
      end
      assign level[i] = level_ff;
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

//--- logic/wave_divider.v
// oscillator tick divider feeding the square-wave taps and the seconds tick
`default_nettype none
`include "rtc_ctrl_map.vh"
module wave_divider #(
  parameter WIDTH = `DIV_WIDTH
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // oscillator tick and run gate
  input  wire             oscTick,
  input  wire             run,
  // divider state
  output wire [WIDTH-1:0] count,
  output wire             secTick
);
  reg [WIDTH-1:0] count_ff;
  reg             secTick_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff   <= {WIDTH{1'b0}};
      secTick_ff <= 1'b0;
    end else begin
      secTick_ff <= oscTick && run && (&count_ff);
      // a halted oscillator freezes the chain in place
      if (oscTick && run) begin
        count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign count   = count_ff;
  assign secTick = secTick_ff;
endmodule // wave_divider
`default_nettype wire

//--- test/rtc_ctrl_props.sv
// concurrent checks on the ports of the rtc control block
`default_nettype none
`include "rtc_ctrl_map.vh"
module rtc_ctrl_props (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic [7:0] regRdData,
  // pins and sensor
  input wire logic       powerFailPin,
  input wire logic       alarmOneMatch,
  input wire logic       alarmTwoMatch,
  input wire logic       sensorDone,
  input wire logic       sensorConvert,
  input wire logic       capUpdate,
  input wire logic       oscEnable,
  input wire logic       irqWavePinOut,
  input wire logic       fixedWavePinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] mainRun_ff;
  // saturating count of cycles on main supply; sync and tick copy need slack
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) mainRun_ff <= 6'h00;
    else if (powerFailPin) mainRun_ff <= 6'h00;
    else if (mainRun_ff != 6'h3F) mainRun_ff <= mainRun_ff + 6'h01;
  a_osc_main_run: assert property (mainRun_ff == 6'h3F |-> oscEnable)
    else $error("oscillator stopped on main supply");
  a_done_ends_convert_request: assert property (sensorConvert && sensorDone |=> !sensorConvert && capUpdate)
    else $error("conversion did not end with a capacitance update");
  a_cap_one_pulse: assert property (capUpdate |=> !capUpdate)
    else $error("capacitance update longer than one cycle");
  a_no_second_convert_request: assert property (capUpdate |-> !sensorConvert)
    else $error("conversion overlaps update");
  a_fixed_oe_follow: assert property (regWrEn && regAddr == `REG_STATUS_OFS |->
    ##2 fixedWavePinOe == $past(regWrData[`ST_FIXED_EN], 2)) else $error("fixed pin enable wrong");
  a_irq_open_drain: assert property (irqWavePinOut == 1'b0)
    else $error("shared pin driven high");
  a_convert_request_bit_clear: assert property (capUpdate && regAddr == `REG_CONTROL_OFS && !regWrEn ##1
    (regAddr == `REG_CONTROL_OFS && !regWrEn) [*2] |=> !regRdData[`CTL_CONVERT])
    else $error("convert bit still set after completion");
  a_alarm_one_set: assert property (alarmOneMatch && regAddr == `REG_STATUS_OFS && !regWrEn ##1
    (regAddr == `REG_STATUS_OFS && !regWrEn) |=> regRdData[`ST_ALARM1]) else $error("alarm one flag not set");
  a_alarm_two_set: assert property (alarmTwoMatch && regAddr == `REG_STATUS_OFS && !regWrEn ##1
    (regAddr == `REG_STATUS_OFS && !regWrEn) |=> regRdData[`ST_ALARM2]) else $error("alarm two flag not set");
endmodule // rtc_ctrl_props
bind rtc_control_status_logic rtc_ctrl_props PROPS (.sys_clk, .arst_n, .regAddr, .regWrData, .regWrEn,
  .regRdData, .powerFailPin, .alarmOneMatch, .alarmTwoMatch, .sensorDone, .sensorConvert, .capUpdate,
  .oscEnable, .irqWavePinOut, .fixedWavePinOe);
`default_nettype wire

//--- test/sensor_model.sv
// temperature sensor stand-in answering conversions after a set latency
`default_nettype none
module sensor_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // conversion handshake
  input  wire logic sensorConvert,
  input  var  int   lat,
  output var  logic sensorDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // driven off the falling edge so the design samples a settled level
  always @(negedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt = 0;
      sensorDone <= 1'b0;
    end else if (!sensorConvert) begin
      cnt = 0;
      sensorDone <= 1'b0;
    end else if (cnt >= lat) begin
      sensorDone <= 1'b1;
    end else begin
      cnt++;
    end
  end
endmodule // sensor_model
`default_nettype wire

//--- test/rtc_control_status_logic_bench.sv
// register-level bench of the rtc control block
`default_nettype none
`include "rtc_ctrl_map.vh"
module rtc_control_status_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 0, arst_n = 0, regWrEn = 0, oscClkPin = 0, powerFailPin = 0;
  logic       alarmOneMatch = 0, alarmTwoMatch = 0, acc;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rdByte;
  wire  logic [7:0] regRdData;
  wire  logic sensorDone, sensorConvert, capUpdate, oscEnable;
  wire  logic irqWavePinOut, irqWavePinOe, fixedWavePinOut, fixedWavePinOe;
  int         mismatches = 0, samplesChecked = 0, lat = 40, rises = 0, d;
  int         per[4] = '{0, 32, 8, 4};
  realtime    t0;
  always #2.5 sys_clk = ~sys_clk;
  // crystal halts while the design disables it
  always #41 if (oscEnable !== 1'b0) oscClkPin = ~oscClkPin;
  always @(posedge sensorConvert) rises++;
  rtc_control_status_logic #(.BUSY_HOLDOFF_CYCLES(20)) DUT (.sys_clk, .arst_n, .regAddr, .regWrData,
    .regWrEn, .regRdData, .oscClkPin, .powerFailPin, .alarmOneMatch, .alarmTwoMatch, .sensorDone,
    .sensorConvert, .capUpdate, .oscEnable, .irqWavePinOut, .irqWavePinOe, .fixedWavePinOut, .fixedWavePinOe);
  sensor_model SENS (.sys_clk, .arst_n, .sensorConvert, .lat, .sensorDone);
  // ==========================================================
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    regAddr = a;
    @(negedge sys_clk);
    rdByte = regRdData;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? sensorConvert : k == 1 ? capUpdate : k == 2 ? irqWavePinOe : fixedWavePinOut;
  endfunction
  task automatic waitFor(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v) begin
      @(negedge sys_clk);
      n++;
      if (n > 3000) begin
        mismatches++;
        $display("[FAIL] %0t wait timed out", $time);
        wrapUp();
      end
    end
  endtask
  // one full period between two rising edges, within three clocks of slack each way
  task automatic period(input int k, input int ns, input string what);
    waitFor(k, 0);
    waitFor(k, 1);
    t0 = $realtime;
    waitFor(k, 0);
    waitFor(k, 1);
    d = int'($realtime - t0) - ns;
    chk(8'(d > -15 && d < 15), 8'h01, what);
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk);
    if (k == 1) alarmOneMatch = 1'b1;
    else alarmTwoMatch = 1'b1;
    @(negedge sys_clk);
    alarmOneMatch = 1'b0;
    alarmTwoMatch = 1'b0;
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    idle(12);
    arst_n = 1'b1;
    rd(`REG_CONTROL_OFS);
    chk(rdByte, `CONTROL_RESET, "control reset");
    rd(`REG_STATUS_OFS);
    chk(rdByte, 8'h88, "status reset");
    rd(8'h20);
    chk(rdByte, 8'h00, "unmapped");
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      wr(`REG_CONTROL_OFS, 8'(r << 3));
      rd(`REG_CONTROL_OFS);
      chk(rdByte, 8'(r << 3), "rate readback");
      if (r > 0) begin
        idle(40);
        period(2, per[r] * 82, "wave period");
      end
    end
    $display("test rate done");
    wr(`REG_CONTROL_OFS, 8'h04);
    rd(`REG_STATUS_OFS);
    idle(40);
    pulse(1);
    idle(6);
    chk(irqWavePinOe, 1'b0, "alarm one masked");
    wr(`REG_CONTROL_OFS, 8'h05);
    idle(4);
    chk(irqWavePinOe, 1'b1, "alarm one on pin");
    rd(`REG_STATUS_OFS);
    pulse(2);
    wr(`REG_STATUS_OFS, 8'h0A);
    idle(4);
    chk(irqWavePinOe, 1'b0, "alarm two masked");
    rd(`REG_STATUS_OFS);
    chk(rdByte & 8'h7F, 8'h0A, "flag clear");
    wr(`REG_CONTROL_OFS, 8'h06);
    idle(4);
    chk(irqWavePinOe, 1'b1, "alarm two on pin");
    wr(`REG_STATUS_OFS, 8'h00);
    idle(4);
    chk(irqWavePinOe, 1'b0, "flags cleared");
    chk(fixedWavePinOe, 1'b0, "fixed pin off");
    wr(`REG_STATUS_OFS, 8'h08);
    rd(`REG_STATUS_OFS);
    chk(rdByte & 8'h7F, 8'h08, "status after");
    period(3, 82, "fixed wave");
    $display("test alarm done");
    for (int j = 0; j < 2; j++) begin
      lat = j == 0 ? 40 : 0;
      rd(`REG_STATUS_OFS);
      chk(rdByte & 8'h04, 8'h00, "busy before request");
      wr(`REG_CONTROL_OFS, 8'h24);
      if (j == 0) begin
        rd(`REG_CONTROL_OFS);
        chk(rdByte, 8'h24, "convert pending");
        waitFor(0, 1);
        rd(`REG_STATUS_OFS);
        chk(rdByte & 8'h04, 8'h00, "busy held off");
        wr(`REG_CONTROL_OFS, 8'h24);
        idle(25);
        rd(`REG_STATUS_OFS);
        chk(rdByte & 8'h04, 8'h04, "busy while running");
      end
      waitFor(1, 1);
      idle(3);
      rd(`REG_CONTROL_OFS);
      chk(rdByte, 8'h04, "convert done");
      rd(`REG_STATUS_OFS);
      chk(rdByte & 8'h04, 8'h00, "busy done");
    end
    idle(100);
    chk(8'(rises), 8'h02, "conversion count");
    $display("test convert done");
    wr(`REG_CONTROL_OFS, 8'h18);
    powerFailPin = 1'b1;
    idle(60);
    acc = 1'b0;
    repeat (40) begin
      @(negedge sys_clk);
      acc = acc | irqWavePinOe;
    end
    chk(acc, 1'b0, "pin floats on battery");
    wr(`REG_CONTROL_OFS, 8'h58);
    idle(40);
    period(2, per[3] * 82, "wave on battery");
    wr(`REG_CONTROL_OFS, 8'h98);
    idle(60);
    chk(oscEnable, 1'b0, "osc stopped");
    wr(`REG_CONTROL_OFS, 8'h18);
    idle(4);
    chk(oscEnable, 1'b1, "osc restarts on battery");
    wr(`REG_CONTROL_OFS, 8'h98);
    idle(60);
    chk(oscEnable, 1'b0, "osc stopped again");
    powerFailPin = 1'b0;
    idle(60);
    chk(oscEnable, 1'b1, "osc on main");
    $display("test battery done");
    wrapUp();
  end
endmodule // rtc_control_status_logic_bench
`default_nettype wire
